// ---- design/bcrb_consts.vh ----
// constants for the buck configuration register bank: offsets, fields, defaults, timing
// assumes inclusion by the bank and the channel start-up sequencer only
`ifndef BCRB_CONSTS_VH
`define BCRB_CONSTS_VH
// ****************************************************
// register offsets
// ****************************************************
`define BCRB_OFS_VSET1 4'h0
`define BCRB_OFS_VSET2 4'h1
`define BCRB_OFS_VSET3 4'h2
`define BCRB_OFS_RAMP1 4'h3
`define BCRB_OFS_RAMP2 4'h4
`define BCRB_OFS_RAMP3 4'h5
`define BCRB_OFS_PEAK1 4'h6
`define BCRB_OFS_PEAK2 4'h7
`define BCRB_OFS_PEAK3 4'h8
`define BCRB_OFS_RATE 4'h9
`define BCRB_OFS_POWER 4'ha
// ****************************************************
// field masks (effective bits; others read zero)
// ****************************************************
`define BCRB_MSK_VSET 8'hff
`define BCRB_MSK_RAMP 8'h77
`define BCRB_MSK_PEAK 8'h07
`define BCRB_MSK_RATE 8'h7f
`define BCRB_MSK_POWER 8'h4f
`define BCRB_EXT_BIT 7
`define BCRB_POWER_SKIP_BIT 3
`define BCRB_POWER_UV_BIT 6
// ****************************************************
// factory defaults
// ****************************************************
`define BCRB_RST_VSET 8'h00
`define BCRB_RST_RAMP 8'h15
`define BCRB_RST_PEAK 8'h05
`define BCRB_RST_RATE 8'h40
`define BCRB_RST_POWER 8'h7f
// ****************************************************
// switching rate and timing
// ****************************************************
`define BCRB_RATE_MAX_CODE 5'h0c
`define BCRB_RATE_BASE_10KHZ 11'd44
`define BCRB_RATE_STEP_10KHZ 11'd14
`define BCRB_CORE_CLK_10KHZ 11'd2000
`define BCRB_REF_FSW_KHZ 440
`define BCRB_SS_UNIT_MS 1
`define BCRB_DLY_UNIT_MS 10
`define BCRB_SS_UNIT_CYC (`BCRB_SS_UNIT_MS * `BCRB_REF_FSW_KHZ)
`define BCRB_DLY_UNIT_CYC (`BCRB_DLY_UNIT_MS * `BCRB_REF_FSW_KHZ)
`endif

// ---- design/bcrb_chan_seq.v ----
// one channel start-up sequencer: delay, then soft-start ramp of the reference code
// assumes a one-cycle switching tick and a one-cycle start pulse from the bank
`timescale 1ns/1ps
`default_nettype none
`include "bcrb_consts.vh"
module bcrb_chan_seq (
	input wire core_clk,
	input wire nrst,
	input wire sw_tick,
	input wire start,
	input wire stop,
	input wire [2:0] wait_code,
	input wire [2:0] ramp_code,
	input wire [6:0] target,
	output reg active_r,
	output reg done_r,
	output reg [6:0] ref_r
);
	localparam ST_IDLE = 4'b0001;
	localparam ST_WAIT = 4'b0010;
	localparam ST_RAMP = 4'b0100;
	localparam ST_ON = 4'b1000;
	reg [3:0] state_r;
	reg [14:0] cnt_r;
	reg [11:0] acc_r;
	wire [14:0] wait_cyc;
	wire [11:0] ramp_cyc;
	wire [11:0] acc_sum;
	wire [31:0] wait_full;
	wire [31:0] ramp_full;
	// times in switching cycles, so they scale with the selected rate
	// products fit easily: 7*4400 in 15 bits, 8*440 in 12 bits
	assign wait_full = wait_code * `BCRB_DLY_UNIT_CYC;
	assign ramp_full = (ramp_code + 32'd1) * `BCRB_SS_UNIT_CYC;
	assign wait_cyc = wait_full[14:0];
	assign ramp_cyc = ramp_full[11:0];
	assign acc_sum = acc_r + {5'h00, target};
	// delay then bresenham ramp: target < ramp_cyc, so one step per tick at most
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_r <= ST_IDLE;
			cnt_r <= 15'h0000;
			acc_r <= 12'h000;
			ref_r <= 7'h00;
			active_r <= 1'b0;
			done_r <= 1'b0;
		end
		else if (stop)
		begin
			state_r <= ST_IDLE;
			ref_r <= 7'h00;
			active_r <= 1'b0;
			done_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				ST_IDLE:
				begin
					if (start)
					begin
						state_r <= ST_WAIT;
						cnt_r <= 15'h0000;
						acc_r <= 12'h000;
						ref_r <= 7'h00;
					end
				end
				ST_WAIT:
				begin
					if (cnt_r >= wait_cyc)
					begin
						state_r <= ST_RAMP;
						active_r <= 1'b1;
						cnt_r <= 15'h0000;
					end
					else if (sw_tick)
						cnt_r <= cnt_r + 15'h0001;
				end
				ST_RAMP:
				begin
					if (cnt_r[11:0] >= ramp_cyc)
					begin
						state_r <= ST_ON;
						ref_r <= target;
						done_r <= 1'b1;
					end
					else if (sw_tick)
					begin
						cnt_r <= cnt_r + 15'h0001;
						if (acc_sum >= ramp_cyc)
						begin
							acc_r <= acc_sum - ramp_cyc;
							ref_r <= ref_r + 7'h01;
						end
						else
							acc_r <= acc_sum;
					end
				end
				ST_ON:
					ref_r <= target; // live code changes follow once ramped
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- design/bcrb_bank.v ----
// configuration register bank for a three-channel buck controller
// assumes a serial bus engine delivering one-cycle read/write strobes and an nvm loader
`timescale 1ns/1ps
`default_nettype none
`include "bcrb_consts.vh"
// Functional notes
// - voltage registers hold a 7-bit code, 0.8 V plus 50 mV per step.
// - external-feedback bit set means the voltage code is ignored.
// - channel 2 and 3 voltage registers default to 00h.
// - ramp code n gives n+1 ms soft-start at 440 kHz.
// - wait code n gives n times 10 ms start delay at 440 kHz.
// - ramp and wait are counted in switching cycles, scaling with rate.
// - ramp/wait registers default to 6 ms ramp and 10 ms wait.
// - ramp/wait registers keep six bits; bits 7 and 3 ignored.
// - peak current code in bits 2:0, 001..110 give 2..4.5 A.
// - peak current registers default to 05h, 4 A.
// - rate code bits 4:0, 00..0C give 0.44..2.12 MHz.
// - rate code defaults to zero, 440 kHz.
// - phase bits 6:5 choose which channels run 180 degrees opposite.
// - phase defaults to 10b, channel 3 opposite; bit 7 ignored.
// - channel 1 voltage register has the same layout as channels 2, 3.
// - power register bits 2:0 pick channels started on enable rising.
module bcrb_bank (
	input wire core_clk,
	input wire nrst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata_r,
	input wire nvm_wr,
	input wire [7:0] nvm_addr,
	input wire [7:0] nvm_data,
	input wire enable_pin,
	output reg [6:0] vcode_ch1_r,
	output reg [6:0] vcode_ch2_r,
	output reg [6:0] vcode_ch3_r,
	output reg external_feedback_sel_ch1_r,
	output reg external_feedback_sel_ch2_r,
	output reg external_feedback_sel_ch3_r,
	output reg [2:0] peak_current_code_ch1_r,
	output reg [2:0] peak_current_code_ch2_r,
	output reg [2:0] peak_current_code_ch3_r,
	output reg [2:0] peak_reserved_r,
	output reg [4:0] switching_rate_code_r,
	output reg rate_reserved_r,
	output reg [2:0] phase_invert_r,
	output reg pulse_skip_en_r,
	output reg uv_high_sel_r,
	output reg sw_tick_r,
	output wire [2:0] ch_active,
	output wire [2:0] ch_ramp_done,
	output wire [6:0] ref_ch1,
	output wire [6:0] ref_ch2,
	output wire [6:0] ref_ch3
);
	// ****************************************************
	// functions
	// ****************************************************
	// map an 8-bit address onto a local register index, f when unmapped
	function [3:0] bcrb_index;
		input [7:0] addr;
		begin
			if (addr[7:4] == 4'h0 && addr[3:0] <= `BCRB_OFS_POWER)
				bcrb_index = addr[3:0];
			else
				bcrb_index = 4'hf;
		end
	endfunction

	// effective-bit mask per register; dropped bits read back zero
	function [7:0] bcrb_mask;
		input [3:0] idx;
		begin
			case (idx)
				`BCRB_OFS_VSET1, `BCRB_OFS_VSET2, `BCRB_OFS_VSET3:
					bcrb_mask = `BCRB_MSK_VSET;
				`BCRB_OFS_RAMP1, `BCRB_OFS_RAMP2, `BCRB_OFS_RAMP3:
					bcrb_mask = `BCRB_MSK_RAMP;
				`BCRB_OFS_PEAK1, `BCRB_OFS_PEAK2, `BCRB_OFS_PEAK3:
					bcrb_mask = `BCRB_MSK_PEAK;
				`BCRB_OFS_RATE:
					bcrb_mask = `BCRB_MSK_RATE;
				`BCRB_OFS_POWER:
					bcrb_mask = `BCRB_MSK_POWER;
				default:
					bcrb_mask = 8'h00;
			endcase
		end
	endfunction

	// peak current codes outside 001..110 are reserved
	function bcrb_peak_bad;
		input [2:0] code;
		begin
			bcrb_peak_bad = (code == 3'h0) || (code == 3'h7);
		end
	endfunction

	// ****************************************************
	// register storage
	// ****************************************************
	reg [7:0] regs_r [0:10];
	reg [7:0] regs_nxt [0:10];
	reg [3:0] wr_idx;
	reg [7:0] wr_val;
	reg wr_go;
	wire [3:0] rd_idx;
	integer i;
	integer j;

	assign rd_idx = bcrb_index(reg_addr);

	// nvm load wins over a host write in the same cycle, restoring stored defaults
	always @*
	begin
		wr_go = 1'b0;
		wr_idx = 4'hf;
		wr_val = 8'h00;
		if (nvm_wr)
		begin
			wr_idx = bcrb_index(nvm_addr);
			wr_val = nvm_data;
			wr_go = (wr_idx != 4'hf);
		end
		else if (reg_wr)
		begin
			wr_idx = rd_idx;
			wr_val = reg_wdata;
			wr_go = (wr_idx != 4'hf);
		end
		for (i = 0; i <= 10; i = i + 1)
			regs_nxt[i] = regs_r[i];
		if (wr_go)
			regs_nxt[wr_idx] = wr_val & bcrb_mask(wr_idx);
	end

	// factory defaults at reset
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			regs_r[`BCRB_OFS_VSET1] <= `BCRB_RST_VSET;
			regs_r[`BCRB_OFS_VSET2] <= `BCRB_RST_VSET;
			regs_r[`BCRB_OFS_VSET3] <= `BCRB_RST_VSET;
			regs_r[`BCRB_OFS_RAMP1] <= `BCRB_RST_RAMP;
			regs_r[`BCRB_OFS_RAMP2] <= `BCRB_RST_RAMP;
			regs_r[`BCRB_OFS_RAMP3] <= `BCRB_RST_RAMP;
			regs_r[`BCRB_OFS_PEAK1] <= `BCRB_RST_PEAK;
			regs_r[`BCRB_OFS_PEAK2] <= `BCRB_RST_PEAK;
			regs_r[`BCRB_OFS_PEAK3] <= `BCRB_RST_PEAK;
			regs_r[`BCRB_OFS_RATE] <= `BCRB_RST_RATE;
			regs_r[`BCRB_OFS_POWER] <= `BCRB_RST_POWER & `BCRB_MSK_POWER;
		end
		else
		begin
			// own loop index, so the decode process keeps its variable to itself
			for (j = 0; j <= 10; j = j + 1)
				regs_r[j] <= regs_nxt[j];
		end
	end

	// ****************************************************
	// register read port
	// ****************************************************
	// data stands one cycle after the read strobe; unmapped reads return zero
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			reg_rdata_r <= 8'h00;
		else if (reg_rd)
		begin
			if (rd_idx != 4'hf)
				reg_rdata_r <= regs_r[rd_idx];
			else
				reg_rdata_r <= 8'h00;
		end
	end

	// ****************************************************
	// decoded settings
	// ****************************************************
	wire [7:0] rate_reg;
	wire [4:0] rate_field;
	reg [2:0] phase_nxt;
	assign rate_reg = regs_r[`BCRB_OFS_RATE];
	assign rate_field = rate_reg[4:0];

	// phase field to per-channel inversion {ch3, ch2, ch1}
	always @*
	begin
		case (rate_reg[6:5])
			2'b00: phase_nxt = 3'b000;
			2'b01: phase_nxt = 3'b001;
			2'b10: phase_nxt = 3'b100;
			2'b11: phase_nxt = 3'b010;
			default: phase_nxt = 3'b000;
		endcase
	end

	// outputs registered so the analog side never sees decode glitches
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			vcode_ch1_r <= 7'h00;
			vcode_ch2_r <= 7'h00;
			vcode_ch3_r <= 7'h00;
			external_feedback_sel_ch1_r <= 1'b0;
			external_feedback_sel_ch2_r <= 1'b0;
			external_feedback_sel_ch3_r <= 1'b0;
			peak_current_code_ch1_r <= 3'h5;
			peak_current_code_ch2_r <= 3'h5;
			peak_current_code_ch3_r <= 3'h5;
			peak_reserved_r <= 3'b000;
			switching_rate_code_r <= 5'h00;
			rate_reserved_r <= 1'b0;
			phase_invert_r <= 3'b100;
			pulse_skip_en_r <= 1'b0;
			uv_high_sel_r <= 1'b0;
		end
		else
		begin
			vcode_ch1_r <= regs_r[`BCRB_OFS_VSET1][6:0];
			vcode_ch2_r <= regs_r[`BCRB_OFS_VSET2][6:0];
			vcode_ch3_r <= regs_r[`BCRB_OFS_VSET3][6:0];
			external_feedback_sel_ch1_r <= regs_r[`BCRB_OFS_VSET1][`BCRB_EXT_BIT];
			external_feedback_sel_ch2_r <= regs_r[`BCRB_OFS_VSET2][`BCRB_EXT_BIT];
			external_feedback_sel_ch3_r <= regs_r[`BCRB_OFS_VSET3][`BCRB_EXT_BIT];
			peak_current_code_ch1_r <= regs_r[`BCRB_OFS_PEAK1][2:0];
			peak_current_code_ch2_r <= regs_r[`BCRB_OFS_PEAK2][2:0];
			peak_current_code_ch3_r <= regs_r[`BCRB_OFS_PEAK3][2:0];
			peak_reserved_r[0] <= bcrb_peak_bad(regs_r[`BCRB_OFS_PEAK1][2:0]);
			peak_reserved_r[1] <= bcrb_peak_bad(regs_r[`BCRB_OFS_PEAK2][2:0]);
			peak_reserved_r[2] <= bcrb_peak_bad(regs_r[`BCRB_OFS_PEAK3][2:0]);
			switching_rate_code_r <= rate_field;
			rate_reserved_r <= (rate_field > `BCRB_RATE_MAX_CODE);
			phase_invert_r <= phase_nxt;
			pulse_skip_en_r <= regs_r[`BCRB_OFS_POWER][`BCRB_POWER_SKIP_BIT];
			uv_high_sel_r <= regs_r[`BCRB_OFS_POWER][`BCRB_POWER_UV_BIT];
		end
	end

	// ****************************************************
	// switching-cycle tick
	// ****************************************************
	// fractional divider in 10 kHz units: 44 + 14*code per core cycle out of 2000
	// gives the exact rate on average; reserved rate codes run at the top rate
	wire [4:0] rate_eff;
	wire [10:0] rate_inc;
	wire [11:0] phase_sum;
	reg [10:0] phase_acc_r;
	assign rate_eff = (rate_field > `BCRB_RATE_MAX_CODE) ? `BCRB_RATE_MAX_CODE : rate_field;
	assign rate_inc = `BCRB_RATE_BASE_10KHZ + rate_eff * `BCRB_RATE_STEP_10KHZ;
	assign phase_sum = {1'b0, phase_acc_r} + {1'b0, rate_inc};

	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			phase_acc_r <= 11'h000;
			sw_tick_r <= 1'b0;
		end
		else if (phase_sum >= {1'b0, `BCRB_CORE_CLK_10KHZ})
		begin
			phase_acc_r <= phase_sum[10:0] - `BCRB_CORE_CLK_10KHZ;
			sw_tick_r <= 1'b1;
		end
		else
		begin
			phase_acc_r <= phase_sum[10:0];
			sw_tick_r <= 1'b0;
		end
	end

	// ****************************************************
	// enable pin and start-up sequencing
	// ****************************************************
	reg en_meta_r;
	reg en_sync_r;
	reg en_last_r;
	reg en_rise_r;
	reg en_fall_r;

	// two-stage synchroniser, edge detection only behind the second stage
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			en_meta_r <= 1'b0;
			en_sync_r <= 1'b0;
			en_last_r <= 1'b0;
			en_rise_r <= 1'b0;
			en_fall_r <= 1'b0;
		end
		else
		begin
			en_meta_r <= enable_pin;
			en_sync_r <= en_meta_r;
			en_last_r <= en_sync_r;
			en_rise_r <= en_sync_r & ~en_last_r;
			en_fall_r <= ~en_sync_r & en_last_r;
		end
	end

	// channels selected in the power register start on an enable rising edge
	wire [2:0] ch_sel;
	wire [6:0] tgt_ch1;
	wire [6:0] tgt_ch2;
	wire [6:0] tgt_ch3;
	assign ch_sel = regs_r[`BCRB_OFS_POWER][2:0];
	// external feedback ramps the full-scale fraction instead of the code
	assign tgt_ch1 = external_feedback_sel_ch1_r ? 7'h7f : vcode_ch1_r;
	assign tgt_ch2 = external_feedback_sel_ch2_r ? 7'h7f : vcode_ch2_r;
	assign tgt_ch3 = external_feedback_sel_ch3_r ? 7'h7f : vcode_ch3_r;

	bcrb_chan_seq u_seq1 (
		.core_clk(core_clk),
		.nrst(nrst),
		.sw_tick(sw_tick_r),
		.start(en_rise_r & ch_sel[0]),
		.stop(en_fall_r),
		.wait_code(regs_r[`BCRB_OFS_RAMP1][6:4]),
		.ramp_code(regs_r[`BCRB_OFS_RAMP1][2:0]),
		.target(tgt_ch1),
		.active_r(ch_active[0]),
		.done_r(ch_ramp_done[0]),
		.ref_r(ref_ch1)
	);

	bcrb_chan_seq u_seq2 (
		.core_clk(core_clk),
		.nrst(nrst),
		.sw_tick(sw_tick_r),
		.start(en_rise_r & ch_sel[1]),
		.stop(en_fall_r),
		.wait_code(regs_r[`BCRB_OFS_RAMP2][6:4]),
		.ramp_code(regs_r[`BCRB_OFS_RAMP2][2:0]),
		.target(tgt_ch2),
		.active_r(ch_active[1]),
		.done_r(ch_ramp_done[1]),
		.ref_r(ref_ch2)
	);

	bcrb_chan_seq u_seq3 (
		.core_clk(core_clk),
		.nrst(nrst),
		.sw_tick(sw_tick_r),
		.start(en_rise_r & ch_sel[2]),
		.stop(en_fall_r),
		.wait_code(regs_r[`BCRB_OFS_RAMP3][6:4]),
		.ramp_code(regs_r[`BCRB_OFS_RAMP3][2:0]),
		.target(tgt_ch3),
		.active_r(ch_active[2]),
		.done_r(ch_ramp_done[2]),
		.ref_r(ref_ch3)
	);
endmodule
`default_nettype wire

// ---- bench/bcrb_bank_sva.sv ----
// checker for the config bank: write decode, flags, read zeros, tick and start-up relations
// assumes a bind onto the bank with matching port names and a single clock domain
`timescale 1ns/1ps
`default_nettype none
module bcrb_bank_sva (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic nvm_wr,
	input wire logic [7:0] reg_rdata_r,
	input wire logic [6:0] vcode_ch2_r,
	input wire logic external_feedback_sel_ch2_r,
	input wire logic [2:0] peak_current_code_ch1_r,
	input wire logic [2:0] peak_reserved_r,
	input wire logic [4:0] switching_rate_code_r,
	input wire logic rate_reserved_r,
	input wire logic [2:0] phase_invert_r,
	input wire logic sw_tick_r,
	input wire logic [2:0] ch_active,
	input wire logic [2:0] ch_ramp_done
);
	// ****
	// helpers
	// ****
	logic [7:0] wd1_r;
	logic [7:0] wd2_r;
	logic [2:0] ph_exp;
	wire host_wr = reg_wr && !nvm_wr;
	// write data delayed to line up with the two-cycle decode lag
	always @(posedge core_clk)
	begin
		wd1_r <= reg_wdata;
		wd2_r <= wd1_r;
	end
	assign ph_exp = wd2_r[6:5] == 2'h0 ? 3'h0 : wd2_r[6:5] == 2'h1 ? 3'h1 : wd2_r[6:5] == 2'h2 ? 3'h4 : 3'h2;
	// ****
	// assertions
	// ****
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	a_rate_write: assert property (host_wr && reg_addr == 8'h09 |-> ##2 switching_rate_code_r == wd2_r[4:0])
		else $error("rate code not decoded from write");
	a_phase_write: assert property (host_wr && reg_addr == 8'h09 |-> ##2 phase_invert_r == ph_exp)
		else $error("phase flags wrong after write");
	a_vcode_write: assert property (host_wr && reg_addr == 8'h01 |-> ##2 {external_feedback_sel_ch2_r, vcode_ch2_r} == wd2_r)
		else $error("voltage code or feedback select wrong");
	a_peak_write: assert property (host_wr && reg_addr == 8'h06 |-> ##2 peak_current_code_ch1_r == wd2_r[2:0])
		else $error("peak code wrong after write");
	a_peak_flag: assert property (peak_reserved_r[0] == (peak_current_code_ch1_r inside {3'h0, 3'h7}))
		else $error("peak reserved flag wrong");
	a_rate_flag: assert property (rate_reserved_r == (switching_rate_code_r > 5'h0c))
		else $error("rate reserved flag wrong");
	a_ramp_dontcare: assert property (reg_rd && reg_addr inside {[8'h03:8'h05]} |=> !reg_rdata_r[7] && !reg_rdata_r[3])
		else $error("ignored ramp bits read back set");
	a_tick_spacing: assert property (sw_tick_r |=> !sw_tick_r [*8])
		else $error("switching ticks too close");
	a_done_active: assert property (ch_ramp_done[0] |-> ch_active[0])
		else $error("ramp done without active");
	c_rate_fast: cover property (host_wr && reg_addr == 8'h09 && reg_wdata[4:0] == 5'h0c);
	c_ch2_active: cover property ($rose(ch_active[1]));
	c_ramp_done: cover property ($rose(ch_ramp_done[0]));
endmodule
`default_nettype wire

// ---- bench/bcrb_host_model.sv ----
// host side of the register port: one-cycle write and read strobes
// assumes the bank samples strobes at rising edges and answers reads one cycle later
`timescale 1ns/1ps
`default_nettype none
module bcrb_host_model (
	input wire logic core_clk,
	input wire logic [7:0] reg_rdata_r,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	int slow = 0;
	// idle bus at time zero
	initial
	begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// released lines show inverted values so stale data never looks valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		repeat (slow) @(posedge core_clk);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge core_clk);
		#1;
		d = reg_rdata_r;
	endtask
endmodule
`default_nettype wire

// ---- bench/bcrb_bank_tb.sv ----
// bench top: bank, host model, register reference model and verdict
// assumes the checker and host model compile first
`timescale 1ns/1ps
`default_nettype none
module bcrb_bank_tb;
	logic core_clk, nrst, nvm_wr, en, rwr, rrd, e1, e2, e3, rres, psm, uv, tick;
	logic [7:0] nva, nvd, ra, rwd, rdat, rv;
	logic [6:0] vc1, vc2, vc3, rf1, rf2, rf3;
	logic [2:0] pk1, pk2, pk3, pres, phi, act, done;
	logic [4:0] rate;
	int mdl[16], t_act[3], t_done[3];
	int err_total, total_checks, ticks, t0, i;
	int wq[$];
	int msk[11] = '{8'hff, 8'hff, 8'hff, 8'h77, 8'h77, 8'h77, 8'h07, 8'h07, 8'h07, 8'h7f, 8'h4f};
	int dflt[11] = '{8'h00, 8'h00, 8'h00, 8'h15, 8'h15, 8'h15, 8'h05, 8'h05, 8'h05, 8'h40, 8'h4f};
	bcrb_bank dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(ra), .reg_wdata(rwd), .reg_wr(rwr), .reg_rd(rrd),
		.reg_rdata_r(rdat), .nvm_wr(nvm_wr), .nvm_addr(nva), .nvm_data(nvd), .enable_pin(en),
		.vcode_ch1_r(vc1), .vcode_ch2_r(vc2), .vcode_ch3_r(vc3), .external_feedback_sel_ch1_r(e1),
		.external_feedback_sel_ch2_r(e2), .external_feedback_sel_ch3_r(e3), .peak_current_code_ch1_r(pk1),
		.peak_current_code_ch2_r(pk2), .peak_current_code_ch3_r(pk3), .peak_reserved_r(pres),
		.switching_rate_code_r(rate), .rate_reserved_r(rres), .phase_invert_r(phi), .pulse_skip_en_r(psm),
		.uv_high_sel_r(uv), .sw_tick_r(tick), .ch_active(act), .ch_ramp_done(done), .ref_ch1(rf1), .ref_ch2(rf2),
		.ref_ch3(rf3));
	bcrb_host_model host (.core_clk(core_clk), .reg_rdata_r(rdat), .reg_addr(ra), .reg_wdata(rwd), .reg_wr(rwr),
		.reg_rd(rrd));
	// ****
	// clock, tick counter, start-up timestamps
	// ****
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// timestamps in switching ticks, so ramp and wait are judged in their own unit
	always @(posedge core_clk)
	begin
		if (tick === 1'b1)
			ticks <= ticks + 1;
		for (int k = 0; k < 3; k++)
		begin
			if (act[k] === 1'b1 && t_act[k] < 0)
				t_act[k] <= ticks;
			if (done[k] === 1'b1 && t_done[k] < 0)
				t_done[k] <= ticks;
		end
	end
	// ****
	// reference model and checks
	// ****
	function automatic logic rsv(input int c);
		return c[2:0] == 3'h0 || c[2:0] == 3'h7;
	endfunction
	function automatic logic [2:0] ph(input int c);
		return c[6:5] == 2'h0 ? 3'h0 : c[6:5] == 2'h1 ? 3'h1 : c[6:5] == 2'h2 ? 3'h4 : 3'h2;
	endfunction
	function automatic int near(input int v, input int e);
		return (v >= e - 2 && v <= e + 2) ? 1 : 0;
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			err_total++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wr(input int a, input int d);
		host.wr(8'(a), 8'(d));
		if (a < 11)
			mdl[a] = d & msk[a];
	endtask
	task automatic rc(input int a);
		host.rd(8'(a), rv);
		chk({24'h0, rv}, a < 11 ? mdl[a] : 0);
	endtask
	// decoded outputs lag a write by two clocks
	task automatic dec();
		logic [31:0] x;
		repeat (3) @(posedge core_clk);
		#1;
		chk({8'h0, e1, vc1, e2, vc2, e3, vc3}, {8'h0, mdl[0][7:0], mdl[1][7:0], mdl[2][7:0]});
		x = {9'h0, mdl[6][2:0], mdl[7][2:0], mdl[8][2:0], rsv(mdl[8]), rsv(mdl[7]), rsv(mdl[6]), mdl[9][4:0],
			mdl[9][4:0] > 5'h0c, ph(mdl[9]), mdl[10][3], mdl[10][6]};
		chk({9'h0, pk1, pk2, pk3, pres, rate, rres, phi, psm, uv}, x);
	endtask
	task automatic defaults();
		for (i = 0; i < 16; i++)
			mdl[i] = i < 11 ? dflt[i] : 0;
		for (int a = 0; a < 13; a++)
			rc(a);
		rc(255);
		dec();
	endtask
	// ****
	// main sequence
	// ****
	initial
	begin
		{nrst, nvm_wr, nva, nvd, en} = '0;
		{ticks, err_total, total_checks} = '0;
		void'($urandom(21));
		repeat (8) @(posedge core_clk);
		nrst <= 1'b1;
		defaults();
		host.slow = 2;
		repeat (30)
		begin
			i = $urandom_range(0, 15);
			wq.push_back(i);
			wr(i, $urandom);
			dec();
		end
		while (wq.size() > 0)
			rc(wq.pop_front());
		host.slow = 0;
		for (i = 0; i < 8; i++)
		begin
			wr(6 + i % 3, i | 8'hf8);
			dec();
		end
		for (i = 0; i < 4; i++)
		begin
			wr(9, 8'h80 | i << 5 | (i == 3 ? 13 : 3 * i));
			dec();
		end
		// nvm load in the same cycle as a host write must win
		fork
			host.wr(8'h01, 8'h55);
			begin
				@(posedge core_clk);
				nvm_wr <= 1'b1;
				nva <= 8'h01;
				nvd <= 8'h2a;
				@(posedge core_clk);
				nvm_wr <= 1'b0;
			end
		join
		mdl[1] = 8'h2a;
		rc(1);
		for (i = 0; i < 13; i += 4)
		begin
			wr(9, i);
			repeat (4) @(posedge core_clk);
			t0 = ticks;
			repeat (1000) @(posedge core_clk);
			chk(near(ticks - t0, 22 + 7 * i), 1);
		end
		// channel 1 no wait, channel 2 one wait step on external feedback, channel 3 not selected
		wr(0, 8'h10);
		wr(1, 8'h85);
		wr(3, 8'h00);
		wr(4, 8'h10);
		wr(10, 8'h43);
		wr(9, 8'h0c);
		t_act = '{-1, -1, -1};
		t_done = '{-1, -1, -1};
		@(posedge core_clk);
		en <= 1'b1;
		t0 = ticks;
		i = 0;
		while (done[1:0] !== 2'b11 && i < 60000)
		begin
			@(posedge core_clk);
			i++;
		end
		if (i >= 60000)
			err_total++;
		// timestamps of this edge land in its update region, so read them after it
		#1;
		chk(near(t_act[0] - t0, 0), 1);
		chk(near(t_act[1] - t0, 4400), 1);
		chk(near(t_done[0] - t_act[0], 440), 1);
		chk(near(t_done[1] - t_act[1], 440), 1);
		chk({10'h0, act[2], rf1, rf2, rf3}, {10'h0, 1'b0, 7'h10, 7'h7f, 7'h00});
		@(posedge core_clk);
		en <= 1'b0;
		repeat (8) @(posedge core_clk);
		#1;
		chk({19'h0, act, done, rf1}, 32'h0);
		@(posedge core_clk);
		nrst <= 1'b0;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		defaults();
		print_verdict();
	end
endmodule
bind bcrb_bank bcrb_bank_sva u_sva (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .nvm_wr,
	.reg_rdata_r, .vcode_ch2_r, .external_feedback_sel_ch2_r, .peak_current_code_ch1_r, .peak_reserved_r,
	.switching_rate_code_r, .rate_reserved_r, .phase_invert_r, .sw_tick_r, .ch_active, .ch_ramp_done);
`default_nettype wire
